/* File: bench/tgsc_timer_sync_tb.sv */
`timescale 1ns/100ps
module tgsc_timer_sync_tb import tgsc_pkg::*;;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [2:0]  split;
  logic [2:0]  duty;
  logic [4:0]  tmr_run;
  logic [2:0]  tmr_low_run;
  logic [4:0]  reload_high_pulse;
  logic [4:0]  reload_low_pulse;
  logic [1:0]  tmr4_pin_route;
  logic        tmr4_fast_clock_sel;
  logic        serial2_pin_route;
  logic        serial3_pin_route;
  int          failures;
  int          checks_done;
  int          cycles;
  logic [31:0] d;
  logic [4:0]  hi;
  logic [4:0]  lo;

  // Single slave, so its ready output is the bus ready
  tgsc_timer_sync dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tmr_split_enable(split),
    .tmr_duty_capture(duty), .tmr_run(tmr_run), .tmr_low_run(tmr_low_run),
    .reload_high_pulse(reload_high_pulse), .reload_low_pulse(reload_low_pulse),
    .tmr4_pin_route(tmr4_pin_route), .tmr4_fast_clock_sel(tmr4_fast_clock_sel),
    .serial2_pin_route(serial2_pin_route), .serial3_pin_route(serial3_pin_route)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One whole-word transfer; waits on ready, so slave latency is never assumed
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr  <= {22'h000000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Page select then strobe write; pulses sampled in the cycle after the write
  task automatic strobe(input logic [3:0] pg, input logic [7:0] val);
    bus(1'b1, IDX_PAGE, {28'h0000000, pg}, d);
    bus(1'b1, IDX_STROBE, {24'h000000, val}, d);
    #1;
    hi = reload_high_pulse;
    lo = reload_low_pulse;
    @(posedge hclk);
    #1;
    check({22'h000000, reload_high_pulse, reload_low_pulse}, 32'h0);
    @(posedge hclk);
  endtask

  task automatic t_reset();
    check({14'h0000, tmr_run, tmr_low_run, reload_high_pulse, reload_low_pulse}, 32'h0);
    check({30'h0, hresp, hreadyout}, 32'h1);
    bus(1'b0, IDX_STATUS, 32'h0, d);
    check(d, 32'h0);
    bus(1'b1, IDX_PAGE, {28'h0000000, PAGE_AUX}, d);
    bus(1'b0, IDX_AUX, 32'h0, d);
    check(d, 32'h0);
    check({28'h0000000, tmr4_pin_route, tmr4_fast_clock_sel, serial2_pin_route}, 32'h0);
  endtask

  task automatic t_start_stop();
    split <= 3'h5;
    strobe(PAGE_START, 8'h00);
    check({27'h0, tmr_run}, 32'h0);
    strobe(PAGE_START, 8'h1F);
    check({24'h000000, tmr_low_run, tmr_run}, 32'h1F);
    strobe(PAGE_START, 8'hE0);
    check({24'h000000, tmr_low_run, tmr_run}, 32'hBF);
    bus(1'b0, IDX_STROBE, 32'h0, d);
    check(d, 32'h0);
    split <= 3'h1;
    strobe(PAGE_STOP, 8'h05);
    check({27'h0, tmr_run}, 32'h1A);
    strobe(PAGE_STOP, 8'hE0);
    check({29'h0, tmr_low_run}, 32'h4);
    strobe(PAGE_STOP, 8'h00);
    bus(1'b0, IDX_STROBE, 32'h0, d);
    check(d, 32'h0);
    bus(1'b0, IDX_STATUS, 32'h0, d);
    check(d, 32'h9A);
  endtask

  // Reload cases: split, duty capture, strobe value, expected high and low pulses
  task automatic t_reload();
    logic [2:0] sp [5] = '{3'h0, 3'h7, 3'h7, 3'h7, 3'h0};
    logic [2:0] dc [5] = '{3'h0, 3'h0, 3'h0, 3'h7, 3'h0};
    logic [7:0] vl [5] = '{8'h1F, 8'h1C, 8'hE0, 8'hFF, 8'hE0};
    logic [9:0] ex [5] = '{10'h3FF, 10'h380, 10'h01C, 10'h063, 10'h000};
    for (int i = 0; i < 5; i++) begin
      split <= sp[i];
      duty  <= dc[i];
      strobe(PAGE_RELOAD, vl[i]);
      check({22'h000000, hi, lo}, {22'h000000, ex[i]});
    end
    bus(1'b0, IDX_STROBE, 32'h0, d);
    check(d, 32'h0);
    duty <= 3'h0;
  endtask

  // A low start strobe with split off, then a pulse held while the clock enable is low
  task automatic t_freeze();
    split <= 3'h0;
    strobe(PAGE_START, 8'hE0);
    check({29'h0, tmr_low_run}, 32'h4);
    bus(1'b1, IDX_PAGE, {28'h0000000, PAGE_RELOAD}, d);
    bus(1'b1, IDX_STROBE, 32'h03, d);
    ce <= 1'b0;
    repeat (3) @(posedge hclk);
    check({22'h000000, reload_high_pulse, reload_low_pulse}, 32'h63);
    ce <= 1'b1;
    repeat (2) @(posedge hclk);
    check({22'h000000, reload_high_pulse, reload_low_pulse}, 32'h0);
  endtask

  task automatic t_pins();
    bus(1'b1, IDX_PAGE, {28'h0000000, PAGE_AUX}, d);
    bus(1'b1, IDX_AUX, 32'h57, d);
    bus(1'b0, IDX_AUX, 32'h0, d);
    check(d, 32'h57);
    check({28'h0, tmr4_pin_route, tmr4_fast_clock_sel, serial2_pin_route}, 32'hF);
    check({31'h0, serial3_pin_route}, 32'h1);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, IDX_AUX, c, d);
      bus(1'b0, IDX_AUX, 32'h0, d);
      check({d[31:0]}, c);
      check({30'h0, tmr4_pin_route}, c);
    end
    // Pin select is hidden behind other pages, so this write must not land
    bus(1'b1, IDX_PAGE, {28'h0000000, PAGE_START}, d);
    bus(1'b1, IDX_AUX, 32'h01, d);
    check({30'h0, tmr4_pin_route}, 32'h3);
    bus(1'b1, 8'h10, 32'hFF, d);
    bus(1'b0, 8'h10, 32'h0, d);
    check(d, 32'h0);
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    failures    = 0;
    checks_done = 0;
    cycles      = 0;
    hresetn     = 1'b0;
    ce          = 1'b1;
    hsel        = 1'b1;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = HSIZE_WORD;
    hwdata      = 32'h0;
    split       = 3'h0;
    duty        = 3'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_start_stop();
    t_reload();
    t_freeze();
    t_pins();
    close_out();
  end
endmodule

/* File: hw/tgsc_ahb_slave.sv */
`timescale 1ns/100ps
module tgsc_ahb_slave import tgsc_pkg::*; #(
  parameter int unsigned HADDR_W = 32
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  input  wire logic               hsel,
  input  wire logic [HADDR_W-1:0] haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [31:0]        hwdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  tgsc_reg_if.bus                 rif
);
  if (HADDR_W < 10) begin : g_chk
    $error("HADDR_W must be at least 10");
  end

  tgsc_bus_t   st;
  tgsc_bus_t   next_st;
  logic [7:0]  ph_idx;
  logic [7:0]  next_ph_idx;
  logic        ph_ok;
  logic        next_ph_ok;
  logic [31:0] next_hrdata;
  logic        accept;
  logic        mapped;

  // Address phase decode; odd sizes and misaligned words fall to unmapped
  always_comb begin
    accept = hsel && hready && htrans[1];
    mapped = (haddr[HADDR_W-1:10] == '0) && (haddr[1:0] == 2'h0) && (hsize == HSIZE_WORD);
    next_st = st;
    next_ph_idx = ph_idx;
    next_ph_ok = ph_ok;
    next_hrdata = hrdata;
    case (st)
      BUS_READ_WAIT: begin
        // One wait state so the read sees any write of the previous data phase
        next_st = BUS_READ_DONE;
        next_hrdata = ph_ok ? {24'h000000, rif.rdata} : 32'h00000000;
      end
      default: begin
        if (accept) begin
          next_st = hwrite ? BUS_WRITE : BUS_READ_WAIT;
          next_ph_idx = haddr[9:2];
          next_ph_ok = mapped;
        end else begin
          next_st = BUS_IDLE;
        end
      end
    endcase
  end

  // Bus phase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= BUS_IDLE;
      ph_idx <= 8'h00;
      ph_ok <= 1'b0;
      hrdata <= 32'h00000000;
    end else if (ce) begin
      st <= next_st;
      ph_idx <= next_ph_idx;
      ph_ok <= next_ph_ok;
      hrdata <= next_hrdata;
    end
  end

  // Strobes toward the core and bus answers
  assign rif.wr_en = (st == BUS_WRITE) && ph_ok;
  assign rif.rd_en = (st == BUS_READ_WAIT) && ph_ok;
  assign rif.idx   = ph_idx;
  assign rif.wdata = hwdata[7:0];
  assign hreadyout = (st != BUS_READ_WAIT);
  assign hresp     = 1'b0; // Always OKAY
endmodule

/* File: hw/tgsc_pkg.sv */
// Functional notes
// RL1: Start strobe sets run bit, timers 0-4
// RL2: Strobes written together start timers together
// RL3: Low start strobe sets low run in split
// RL4: Strobes self-clear; writing zero does nothing
// RL5: Reload outside split reloads both bytes
// RL6: Reload in split reloads high byte only
// RL7: Low reload strobe reloads low byte in split
// RL8: Forced reload ignored during duty capture
// RL9: Timer 0/1 reload strobe reloads both bytes
// RL10: Stop strobe clears run bit, timers 0-4
// RL11: Low stop strobe clears low run in split
// RL12: Timers in bits 0-4, low halves 5-7
// RL13: Two-bit field routes timer 4 pins, reset 00
// RL14: Split mode makes two 8-bit halves
// RL15: Low run bit starts/stops low counter
// RL16: Software writes zero to pin-select bits 7,5,3
// RL17: Strobe registers always read as zero
package tgsc_pkg;
  localparam int unsigned N_TMR   = 5;
  localparam int unsigned N_SPLIT = 3;
  localparam int unsigned LOW_LSB = 5;
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_STROBE = 8'h95;
  localparam logic [7:0] IDX_AUX    = 8'hA4;
  localparam logic [7:0] IDX_STATUS = 8'hFE;
  localparam logic [7:0] IDX_PAGE   = 8'hFF;
  // Page codes that pick the register behind a shared index
  localparam logic [3:0] PAGE_START  = 4'h1;
  localparam logic [3:0] PAGE_RELOAD = 4'h2;
  localparam logic [3:0] PAGE_STOP   = 4'h3;
  localparam logic [3:0] PAGE_AUX    = 4'hA;
  localparam logic [3:0] PAGE_RESET  = 4'h0;
  // Pin-select fields
  localparam logic [7:0] AUX_RESET  = 8'h00;
  localparam logic [7:0] AUX_WMASK  = 8'h57;
  localparam int unsigned T4_ROUTE_LSB = 0;
  localparam int unsigned T4_FAST_BIT  = 2;
  localparam int unsigned S2_ROUTE_BIT = 4;
  localparam int unsigned S3_ROUTE_BIT = 6;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} tgsc_bus_t;
endpackage

/* File: hw/tgsc_reg_if.sv */
`timescale 1ns/100ps
// Decoded register access between bus front end and core
interface tgsc_reg_if;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus  (output wr_en, rd_en, idx, wdata, input rdata);
  modport core (input wr_en, rd_en, idx, wdata, output rdata);
endinterface

/* File: hw/tgsc_timer_sync.sv */
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
module tgsc_timer_sync import tgsc_pkg::*; #(
  parameter int unsigned HADDR_W = 32
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  input  wire logic               hsel,
  input  wire logic [HADDR_W-1:0] haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [31:0]        hwdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic [2:0]         tmr_split_enable,
  input  wire logic [2:0]         tmr_duty_capture,
  output logic [4:0]              tmr_run,
  output logic [2:0]              tmr_low_run,
  output logic [4:0]              reload_high_pulse,
  output logic [4:0]              reload_low_pulse,
  output logic [1:0]              tmr4_pin_route,
  output logic                    tmr4_fast_clock_sel,
  output logic                    serial2_pin_route,
  output logic                    serial3_pin_route
);
  tgsc_reg_if rif ();

  // Bus front end
  tgsc_ahb_slave #(
    .HADDR_W (HADDR_W)
  ) u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rif       (rif)
  );

  logic [3:0] page;
  logic [3:0] next_page;
  logic [7:0] aux;
  logic [7:0] next_aux;
  logic [7:0] start_q;
  logic [7:0] next_start;
  logic [7:0] stop_q;
  logic [7:0] next_stop;
  logic [4:0] next_rl_high;
  logic [4:0] next_rl_low;
  logic [4:0] next_run;
  logic [2:0] next_low_run;
  logic       wr_strobe;
  logic       wr_start;
  logic       wr_reload;
  logic       wr_stop;
  logic       wr_aux;

  // Decode of a write to the shared strobe index, picked by the page register
  function automatic logic page_hit(input logic en, input logic [7:0] idx,
                                    input logic [3:0] pg, input logic [3:0] want);
    page_hit = en && (idx == IDX_STROBE) && (pg == want);
  endfunction

  assign wr_strobe = ce && rif.wr_en;
  assign wr_start  = page_hit(wr_strobe, rif.idx, page, PAGE_START);
  assign wr_reload = page_hit(wr_strobe, rif.idx, page, PAGE_RELOAD);
  assign wr_stop   = page_hit(wr_strobe, rif.idx, page, PAGE_STOP);
  assign wr_aux    = wr_strobe && (rif.idx == IDX_AUX) && (page == PAGE_AUX);

  // Configuration registers: page and pin select
  always_comb begin
    next_page = page;
    next_aux = aux;
    if (wr_strobe && (rif.idx == IDX_PAGE)) begin
      next_page = rif.wdata[3:0];
    end
    if (wr_aux) begin
      // Bits 7, 5, 3 hold nothing; a stray one is dropped here
      next_aux = rif.wdata & AUX_WMASK; // RL13 RL16
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page <= PAGE_RESET;
      aux <= AUX_RESET; // RL13
    end else if (ce) begin
      page <= next_page;
      aux <= next_aux;
    end
  end

  assign tmr4_pin_route      = aux[T4_ROUTE_LSB +: 2]; // RL13
  assign tmr4_fast_clock_sel = aux[T4_FAST_BIT];
  assign serial2_pin_route   = aux[S2_ROUTE_BIT];
  assign serial3_pin_route   = aux[S3_ROUTE_BIT];

  // Strobe pulses: each lives one enabled cycle, then clears itself
  always_comb begin
    next_start = wr_start ? rif.wdata : 8'h00; // RL4 RL12
    next_stop  = wr_stop ? rif.wdata : 8'h00; // RL4 RL12
    next_rl_high = 5'h00;
    next_rl_low  = 5'h00;
    if (wr_reload) begin
      // Timers 0 and 1 have no split mode: both bytes always
      next_rl_high[1:0] = rif.wdata[1:0]; // RL9
      next_rl_low[1:0]  = rif.wdata[1:0]; // RL9
      for (int j = 0; j < N_SPLIT; j++) begin
        if (!tmr_duty_capture[j]) begin // RL8
          next_rl_high[2+j] = rif.wdata[2+j]; // RL5 RL6
          // Split: low byte only from its own strobe; else it follows the main
          next_rl_low[2+j] = tmr_split_enable[j] ? rif.wdata[LOW_LSB+j]
                                                 : rif.wdata[2+j]; // RL5 RL7 RL14
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q <= 8'h00;
      stop_q <= 8'h00;
      reload_high_pulse <= 5'h00;
      reload_low_pulse <= 5'h00;
    end else if (ce) begin
      start_q <= next_start;
      stop_q <= next_stop;
      reload_high_pulse <= next_rl_high;
      reload_low_pulse <= next_rl_low;
    end
  end

  // Run-control bits; every timer named in one write flips on the same edge
  always_comb begin
    next_run = (tmr_run | start_q[N_TMR-1:0]) & ~stop_q[N_TMR-1:0]; // RL1 RL2 RL10
    // Low halves only react while their timer is split
    next_low_run = (tmr_low_run | (start_q[7:LOW_LSB] & tmr_split_enable))
                   & ~(stop_q[7:LOW_LSB] & tmr_split_enable); // RL3 RL11 RL15
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_run <= 5'h00;
      tmr_low_run <= 3'h0;
    end else if (ce) begin
      tmr_run <= next_run;
      tmr_low_run <= next_low_run;
    end
  end

  // Read mux; strobes never show their pulse to software
  always_comb begin
    rif.rdata = 8'h00; // RL17
    if (rif.idx == IDX_PAGE) begin
      rif.rdata = {4'h0, page};
    end else if (rif.idx == IDX_STATUS) begin
      rif.rdata = {tmr_low_run, tmr_run};
    end else if ((rif.idx == IDX_AUX) && (page == PAGE_AUX)) begin
      rif.rdata = aux & AUX_WMASK;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_start_sets_run: assert property ( // RL1
    wr_start ##1 ce |=> ((tmr_run & $past(rif.wdata[4:0], 2)) == $past(rif.wdata[4:0], 2)))
    else $error("start strobe did not set run bits");

  a_zero_no_effect: assert property ( // RL4
    (wr_start || wr_stop) && (rif.wdata == 8'h00) ##1 ce |=> (tmr_run == $past(tmr_run)))
    else $error("zero strobe write changed run bits");

  a_stop_clears_run: assert property ( // RL10
    wr_stop ##1 ce |=> ((tmr_run & $past(rif.wdata[4:0], 2)) == 5'h00))
    else $error("stop strobe did not clear run bits");

  // Split is judged when the pulse register is applied, one cycle after the write
  a_low_start_split: assert property ( // RL3
    wr_start ##1 ce |=>
      ((tmr_low_run & $past(rif.wdata[7:5], 2) & $past(tmr_split_enable))
       == ($past(rif.wdata[7:5], 2) & $past(tmr_split_enable))))
    else $error("low start strobe did not set low run");

  a_low_stop_split: assert property ( // RL11
    wr_stop ##1 ce |=>
      ((tmr_low_run & $past(rif.wdata[7:5], 2) & $past(tmr_split_enable)) == 3'h0))
    else $error("low stop strobe did not clear low run");

  a_low_only_split: assert property ( // RL15
    ce && (start_q[7:5] != 3'h0) && (tmr_split_enable == 3'h0)
    |=> (tmr_low_run == $past(tmr_low_run)))
    else $error("low run moved outside split mode");

  a_strobe_self_clear: assert property ( // RL4
    ce && (start_q != 8'h00) && !wr_start |=> (start_q == 8'h00))
    else $error("start strobe did not clear itself");

  a_reload_duty_block: assert property ( // RL8
    wr_reload |=> (((reload_high_pulse[4:2] | reload_low_pulse[4:2])
                    & $past(tmr_duty_capture)) == 3'h0))
    else $error("reload passed during duty capture");

  a_reload_full_pair: assert property ( // RL5
    wr_reload |=> ((reload_low_pulse[4:2] & ~$past(tmr_split_enable))
                   == (reload_high_pulse[4:2] & ~$past(tmr_split_enable))))
    else $error("non-split reload not on both bytes");

  a_reload_split_low: assert property ( // RL7
    wr_reload |=> ((reload_low_pulse[4:2] & $past(tmr_split_enable)) ==
      ($past(rif.wdata[7:5]) & $past(tmr_split_enable) & ~$past(tmr_duty_capture))))
    else $error("split low reload wrong");

  a_reload_t01_both: assert property ( // RL9
    wr_reload |=> (reload_high_pulse[1:0] == $past(rif.wdata[1:0]))
                  && (reload_low_pulse[1:0] == $past(rif.wdata[1:0])))
    else $error("timer 0/1 reload wrong");

  a_strobe_reads_zero: assert property ( // RL17
    rif.rd_en && (rif.idx == IDX_STROBE) |-> (rif.rdata == 8'h00))
    else $error("strobe register read nonzero");

  a_pin_route_write: assert property ( // RL13
    wr_aux |=> (tmr4_pin_route == $past(rif.wdata[1:0])))
    else $error("pin route not stored");

  // Only the named timers may move, and all of them on one edge
  a_start_only_named: assert property ( // RL2
    wr_start ##1 ce |=> (((tmr_run ^ $past(tmr_run)) & ~$past(rif.wdata[4:0], 2)) == 5'h00))
    else $error("start strobe moved an unnamed timer");

  // Split timers take the main reload on the high byte alone
  a_reload_split_high: assert property ( // RL6
    wr_reload |=> ((reload_high_pulse[4:2] & $past(tmr_split_enable)) ==
      ($past(rif.wdata[4:2]) & $past(tmr_split_enable) & ~$past(tmr_duty_capture))))
    else $error("split high reload wrong");

  // Outside split the low byte follows the main strobe, not its own
  a_split_off_low: assert property ( // RL14
    wr_reload |=> ((reload_low_pulse[4:2] & ~$past(tmr_split_enable)) ==
      ($past(rif.wdata[4:2]) & ~$past(tmr_split_enable) & ~$past(tmr_duty_capture))))
    else $error("non-split low reload wrong");

  a_zero_no_reload: assert property ( // RL4
    wr_reload && (rif.wdata == 8'h00) |=> ((reload_high_pulse | reload_low_pulse) == 5'h00))
    else $error("zero reload write gave a pulse");

  // A pulse that outlived its cycle would reload the counters twice
  a_reload_pulse_clear: assert property ( // RL4
    ce && !wr_reload |=> ((reload_high_pulse | reload_low_pulse) == 5'h00))
    else $error("reload pulse did not clear itself");

  a_stop_self_clear: assert property ( // RL4
    ce && !wr_stop |=> (stop_q == 8'h00))
    else $error("stop strobe did not clear itself");

  // Run bits move only when a strobe is pending
  a_run_no_stray: assert property ( // RL1
    ce && (start_q[4:0] == 5'h00) && (stop_q[4:0] == 5'h00) |=> (tmr_run == $past(tmr_run)))
    else $error("run bits moved without a strobe");

  a_low_run_no_stray: assert property ( // RL15
    ce && (start_q[7:5] == 3'h0) && (stop_q[7:5] == 3'h0)
    |=> (tmr_low_run == $past(tmr_low_run)))
    else $error("low run bits moved without a strobe");

  // Enable low holds every register, pulses included
  a_freeze_state: assert property ( // RL4
    !ce |=> (tmr_run == $past(tmr_run)) && (tmr_low_run == $past(tmr_low_run))
            && (reload_high_pulse == $past(reload_high_pulse))
            && (reload_low_pulse == $past(reload_low_pulse))
            && (aux == $past(aux)) && (page == $past(page)))
    else $error("state moved while clock enable low");

  a_aux_hold: assert property ( // RL13
    ce && !wr_aux |=> (aux == $past(aux)))
    else $error("pin select changed without a write");

  // The page picks which strobe register a write reaches
  a_page_write: assert property (
    wr_strobe && (rif.idx == IDX_PAGE) |=> (page == $past(rif.wdata[3:0])))
    else $error("page register not stored");

  // Read data come from the mux in the wait cycle
  a_read_data_path: assert property ( // RL17
    rif.rd_en && ce |=> (hrdata == {24'h000000, $past(rif.rdata)}))
    else $error("read data not taken from the register mux");

  // A read stalls the bus for exactly one enabled cycle
  a_wait_one_cycle: assert property (
    !hreadyout && ce |=> hreadyout)
    else $error("read wait longer than one cycle");

  c_multi_start: cover property (wr_start ##1 ce ##1 (tmr_run == 5'h1F));
  c_freeze_pulse: cover property (!ce && (reload_high_pulse != 5'h00));
  c_split_reload: cover property (wr_reload && (tmr_split_enable != 3'h0));
  c_duty_block: cover property (wr_reload && (tmr_duty_capture != 3'h0));
  c_low_stop: cover property (wr_stop && (rif.wdata[7:5] != 3'h0));
endmodule
